/* File: src/ep_ctx_pkg.sv */
package ep_ctx_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_DATA     = 8'h04;
  localparam logic [7:0] OFS_TRANSFER = 8'h08;
  localparam logic [7:0] OFS_AVAIL    = 8'h0c;
  localparam logic [7:0] OFS_BSTATE   = 8'h10;
  localparam logic [7:0] OFS_STAT1    = 8'h14;
  localparam logic [7:0] OFS_RSPSET   = 8'h18;
  localparam logic [7:0] OFS_RSPCLR   = 8'h1c;
  localparam logic [7:0] OFS_IRQENB   = 8'h20;
  localparam logic [7:0] OFS_MAXPKT   = 8'h24;
  localparam logic [7:0] OFS_USBCTL1  = 8'h28;
  localparam logic [7:0] OFS_VIRT_IN  = 8'h2c;
  localparam logic [7:0] OFS_VIRT_OUT = 8'h30;
  // Configuration register fields
  localparam int CFG_EPNUM_LSB = 0;
  localparam int CFG_TYPE_LSB  = 5;
  localparam int CFG_DIR_BIT   = 4;
  localparam int CFG_EN_BIT    = 7;
  // Status register 1 fields
  localparam int STAT1_ZLP_BIT   = 6;
  localparam int STAT1_FLUSH_BIT = 7;
  // Buffer state fields
  localparam int BST_WAIT_BIT  = 0;
  localparam int BST_ZLP_BIT   = 1;
  localparam int BST_UNVAL_BIT = 2;
  // Response fields
  localparam int RSP_HALT_BIT   = 0;
  localparam int RSP_TOGGLE_BIT = 1;
  // Control register 1 fields
  localparam int CTL1_VEP_BIT = 0;
  // Widths and depth
  localparam int CNT_W     = 24;
  localparam int MAXPKT_W  = 11;
  localparam int BUF_AW    = 6;
  localparam int BUF_DEPTH = 64;
  // Reset values
  localparam logic [7:0]          CFG_RST    = 8'h00;
  localparam logic [7:0]          RSP_RST    = 8'h00;
  localparam logic [7:0]          IRQENB_RST = 8'h00;
  localparam logic [MAXPKT_W-1:0] MAXPKT_RST = 11'h040;
  localparam logic [CNT_W-1:0]    CNT_RST    = 24'h000000;
  localparam logic [15:0]         VIRT_RST   = 16'h0000;
endpackage : ep_ctx_pkg

/* File: src/ep_byte_buffer.sv */
`timescale 1ns/100ps
// Byte store with a validated region, an unvalidated tail and flush
module ep_byte_buffer
  import ep_ctx_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // Fill side
  input  wire logic                wr_en_i,
  input  wire logic [7:0]          wr_data_i,
  input  wire logic                commit_i,
  input  wire logic                drop_i,
  input  wire logic                flush_i,
  // Drain side
  input  wire logic                rd_en_i,
  output logic      [7:0]          rd_data_o,
  // Levels
  output logic      [BUF_AW:0]     avail_o,
  output logic      [BUF_AW:0]     pending_o,
  output logic                     full_o
);
  logic [7:0]    mem_q [BUF_DEPTH];
  logic [BUF_AW:0] wr_ptr_q;
  logic [BUF_AW:0] val_ptr_q;
  logic [BUF_AW:0] rd_ptr_q;
  logic            wr_ok;
  logic            rd_ok;

  // Level arithmetic on wrapping pointers
  assign avail_o   = val_ptr_q - rd_ptr_q;
  assign pending_o = wr_ptr_q - val_ptr_q;
  assign full_o    = (wr_ptr_q - rd_ptr_q) == (BUF_AW+1)'(BUF_DEPTH);
  assign wr_ok     = wr_en_i && !full_o;
  assign rd_ok     = rd_en_i && (avail_o != '0);
  assign rd_data_o = mem_q[rd_ptr_q[BUF_AW-1:0]];

  // Storage; writes to a full buffer are ignored
  always_ff @(posedge ref_clk_i) begin
    if (wr_ok) begin
      mem_q[wr_ptr_q[BUF_AW-1:0]] <= wr_data_i;
    end
  end

  // Pointers; commit covers a byte written in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q  <= '0;
      val_ptr_q <= '0;
      rd_ptr_q  <= '0;
    end else if (flush_i) begin
      wr_ptr_q  <= '0;
      val_ptr_q <= '0;
      rd_ptr_q  <= '0;
    end else begin
      if (drop_i) begin
        wr_ptr_q <= val_ptr_q;
      end else if (wr_ok) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (commit_i) begin
        val_ptr_q <= wr_ok ? wr_ptr_q + 1'b1 : wr_ptr_q;
      end
      if (rd_ok) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule : ep_byte_buffer

/* File: src/ep_ctx_switch.sv */
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module ep_ctx_switch
  import ep_ctx_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // USB protocol side
  input  wire logic                    usb_busy_i,
  input  wire logic                    tok_valid_i,
  input  wire logic                    tok_in_i,
  input  wire logic [3:0]              tok_ep_i,
  output logic                         tok_nak_o,
  output logic                         tok_timeout_o,
  output logic                         ep_enable_o
);
  import ep_ctx_pkg::*;

  logic                ack_q;
  logic [31:0]         dat_q;
  logic [7:0]          cfg_q;
  logic                en_q;
  logic                en_req_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [7:0]          rsp_q;
  logic [7:0]          irqenb_q;
  logic [MAXPKT_W-1:0] maxpkt_q;
  logic                vep_q;
  logic [15:0]         virt_in_q;
  logic [15:0]         virt_out_q;
  logic                zlp_q;
  logic                nak_q;
  logic                tmo_q;
  logic                req;
  logic                wr;
  logic                rd;
  logic                dir_in;
  logic                data_wr;
  logic                data_rd;
  logic                cnt_wr;
  logic [CNT_W-1:0]    cnt_new;
  logic                validate;
  logic                drop;
  logic                flush;
  logic                unassigned;
  logic [7:0]          buf_rd_data;
  logic [BUF_AW:0]     avail;
  logic [BUF_AW:0]     pending;
  logic                buf_full;
  logic [2:0]          bstate;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Access decode; one request is taken per handshake
  assign req     = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr      = req && wb_we_i;
  assign rd      = req && !wb_we_i;
  assign dir_in  = cfg_q[CFG_DIR_BIT];
  assign data_wr = wr && (wb_adr_i == OFS_DATA) && wb_sel_i[0] && dir_in;
  assign data_rd = rd && (wb_adr_i == OFS_DATA) && !dir_in;
  assign cnt_wr  = wr && (wb_adr_i == OFS_TRANSFER) && dir_in;
  assign cnt_new = CNT_W'(merge({8'h00, cnt_q}, wb_dat_i, wb_sel_i));

  // Validate on zero written, or counter reaching zero while loading
  assign validate = (cnt_wr && cnt_new == '0) ||
                    (data_wr && cnt_q == CNT_W'(1));
  // Leaving IN discards the unvalidated tail
  assign drop  = wr && (wb_adr_i == OFS_CFG) && wb_sel_i[0] && dir_in &&
                 !wb_dat_i[CFG_DIR_BIT];
  assign flush = wr && (wb_adr_i == OFS_STAT1) && wb_sel_i[0] && wb_dat_i[STAT1_FLUSH_BIT];

  // Buffer states: waiting for host, local zero-length, unvalidated data
  assign bstate[BST_WAIT_BIT]  = dir_in && (avail != '0 || zlp_q);
  assign bstate[BST_ZLP_BIT]   = zlp_q;
  assign bstate[BST_UNVAL_BIT] = pending != '0;

  ep_byte_buffer u_buf (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (data_wr),
    .wr_data_i (wb_dat_i[7:0]),
    .commit_i  (validate),
    .drop_i    (drop),
    .flush_i   (flush),
    .rd_en_i   (data_rd),
    .rd_data_o (buf_rd_data),
    .avail_o   (avail),
    .pending_o (pending),
    .full_o    (buf_full)
  );

  // Bus handshake and read data
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (rd) begin
        case (wb_adr_i)
          OFS_CFG:      dat_q <= {24'h000000, en_q, cfg_q[6:0]};
          OFS_DATA:     dat_q <= dir_in ? 32'h0000_0000 : {24'h000000, buf_rd_data};
          OFS_TRANSFER: dat_q <= {8'h00, cnt_q};
          OFS_AVAIL:    dat_q <= {25'h0000000, avail};
          OFS_BSTATE:   dat_q <= {29'h00000000, bstate};
          OFS_STAT1:    dat_q <= {25'h0000000, zlp_q, 6'h00};
          OFS_RSPSET:   dat_q <= {24'h000000, rsp_q};
          OFS_RSPCLR:   dat_q <= {24'h000000, rsp_q};
          OFS_IRQENB:   dat_q <= {24'h000000, irqenb_q};
          OFS_MAXPKT:   dat_q <= {21'h000000, maxpkt_q};
          OFS_USBCTL1:  dat_q <= {31'h00000000, vep_q};
          OFS_VIRT_IN:  dat_q <= {16'h0000, virt_in_q};
          OFS_VIRT_OUT: dat_q <= {16'h0000, virt_out_q};
          default:      dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Configuration fields in a single write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q    <= CFG_RST;
      en_req_q <= 1'b0;
    end else if (wr && wb_adr_i == OFS_CFG && wb_sel_i[0]) begin
      cfg_q    <= {1'b0, wb_dat_i[6:0]};
      en_req_q <= wb_dat_i[CFG_EN_BIT];
    end
  end

  // Enable follows the request only between transactions
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q <= 1'b0;
    end else if (!usb_busy_i) begin
      en_q <= en_req_q;
    end
  end
  assign ep_enable_o = en_q;

  // Transfer byte counter: load, or count down on data loading
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= CNT_RST;
    end else if (wr && wb_adr_i == OFS_TRANSFER) begin
      cnt_q <= cnt_new;
    end else if (data_wr && !buf_full && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Local zero-length packet flag
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zlp_q <= 1'b0;
    end else if (cnt_wr && cnt_new == '0 && pending == '0) begin
      zlp_q <= 1'b1;
    end else if (flush || (data_rd && avail == '0)) begin
      zlp_q <= 1'b0;
    end
  end

  // Response bits; clearing halt clears toggle as well
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_q <= RSP_RST;
    end else if (wr && wb_adr_i == OFS_RSPSET && wb_sel_i[0]) begin
      rsp_q <= rsp_q | wb_dat_i[7:0];
    end else if (wr && wb_adr_i == OFS_RSPCLR && wb_sel_i[0]) begin
      rsp_q <= rsp_q & ~wb_dat_i[7:0];
      if (wb_dat_i[RSP_HALT_BIT]) begin
        rsp_q[RSP_TOGGLE_BIT] <= 1'b0;
      end
    end
  end

  // Storage registers saved and restored by firmware; vep_q also picks NAK or timeout for unassigned tokens
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irqenb_q <= IRQENB_RST;
      maxpkt_q <= MAXPKT_RST;
      vep_q    <= 1'b0;
    end else if (wr) begin
      if (wb_adr_i == OFS_IRQENB && wb_sel_i[0]) begin
        irqenb_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == OFS_MAXPKT) begin
        maxpkt_q <= MAXPKT_W'(merge({21'h000000, maxpkt_q}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == OFS_USBCTL1 && wb_sel_i[0]) begin
        vep_q <= wb_dat_i[CTL1_VEP_BIT];
      end
    end
  end

  // Token to an endpoint this one does not serve
  assign unassigned = tok_valid_i &&
                      !(en_q && cfg_q[CFG_EPNUM_LSB +: 4] == tok_ep_i && dir_in == tok_in_i);

  // Virtual endpoint answers and pending bits; set wins over clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nak_q      <= 1'b0;
      tmo_q      <= 1'b0;
      virt_in_q  <= VIRT_RST;
      virt_out_q <= VIRT_RST;
    end else begin
      nak_q <= unassigned && vep_q;
      tmo_q <= unassigned && !vep_q;
      if (wr && wb_adr_i == OFS_VIRT_IN) begin
        virt_in_q <= virt_in_q & ~16'(merge(32'h0, wb_dat_i, wb_sel_i));
      end
      if (wr && wb_adr_i == OFS_VIRT_OUT) begin
        virt_out_q <= virt_out_q & ~16'(merge(32'h0, wb_dat_i, wb_sel_i));
      end
      if (unassigned && vep_q && tok_in_i) begin
        virt_in_q[tok_ep_i] <= 1'b1;
      end
      if (unassigned && vep_q && !tok_in_i) begin
        virt_out_q[tok_ep_i] <= 1'b1;
      end
    end
  end
  assign tok_nak_o     = nak_q;
  assign tok_timeout_o = tmo_q;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_taken;
    req;
  endsequence
  sequence s_answer;
    ack_q ##1 !ack_q;
  endsequence

  property p_bus_answer;
    s_taken |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus ack not one cycle after request");

  property p_in_write_only;
    rd && wb_adr_i == OFS_DATA && dir_in |=> wb_dat_o == 32'h0 && $stable(avail);
  endproperty
  a_in_write_only: assert property (p_in_write_only) else $error("IN read not blocked");

  property p_validate;
    cnt_wr && cnt_new == '0 |=> pending == '0 && avail >= $past(pending);
  endproperty
  a_validate: assert property (p_validate) else $error("zero write did not validate");

  property p_low_byte;
    cnt_wr && wb_sel_i == 4'h1 && wb_dat_i[7:0] == 8'h00 && cnt_q[23:8] == '0 |=> pending == '0;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte zero not validated");

  property p_avail;
    rd && wb_adr_i == OFS_AVAIL |=> wb_dat_o[BUF_AW:0] == $past(avail);
  endproperty
  a_avail: assert property (p_avail) else $error("available count mismatch");

  property p_zlp_dummy;
    data_rd && avail == '0 && zlp_q |=> !zlp_q;
  endproperty
  a_zlp_dummy: assert property (p_zlp_dummy) else $error("dummy read kept ZLP flag");

  property p_zlp_flag;
    rd && wb_adr_i == OFS_STAT1
      |=> wb_dat_o[STAT1_ZLP_BIT] == $past(zlp_q) && bstate[BST_ZLP_BIT] == zlp_q;
  endproperty
  a_zlp_flag: assert property (p_zlp_flag) else $error("zero-length flag misreported");

  property p_discard;
    drop && !validate |=> pending == '0 && avail == $past(avail);
  endproperty
  a_discard: assert property (p_discard) else $error("unvalidated data kept");

  property p_halt_toggle;
    wr && wb_adr_i == OFS_RSPCLR && wb_sel_i[0] && wb_dat_i[RSP_HALT_BIT]
      |=> !rsp_q[RSP_HALT_BIT] && !rsp_q[RSP_TOGGLE_BIT];
  endproperty
  a_halt_toggle: assert property (p_halt_toggle) else $error("halt clear kept toggle");

  property p_enable_hold;
    usb_busy_i |=> $stable(en_q);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable moved while busy");

  property p_virtual;
    unassigned |=> (tok_nak_o == $past(vep_q)) && (tok_timeout_o == !$past(vep_q));
  endproperty
  a_virtual: assert property (p_virtual) else $error("wrong unassigned answer");
endmodule : ep_ctx_switch

/* File: verif/usb_host_model.sv */
`timescale 1ns/100ps
// Host side: issues tokens and holds the transaction-busy level
module usb_host_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // Handshake answers from the endpoint logic
  input  wire logic       tok_nak_i,
  input  wire logic       tok_timeout_i,
  // Token and activity outputs
  output logic            usb_busy_o,
  output logic            tok_valid_o,
  output logic            tok_in_o,
  output logic [3:0]      tok_ep_o
);
  // Idle values at time zero
  initial begin
    usb_busy_o  = 1'b0;
    tok_valid_o = 1'b0;
    tok_in_o    = 1'b0;
    tok_ep_o    = 4'h0;
  end
  // One token; fields turn over once it is gone, answer seen a cycle later
  task automatic send_token(input logic in, input logic [3:0] ep,
                            output logic nak, output logic tmo);
    @(posedge ref_clk_i);
    tok_valid_o <= 1'b1;
    tok_in_o    <= in;
    tok_ep_o    <= ep;
    @(posedge ref_clk_i);
    tok_valid_o <= 1'b0;
    tok_in_o    <= ~in;
    tok_ep_o    <= ~ep;
    #1;
    nak = tok_nak_i;
    tmo = tok_timeout_i;
  endtask : send_token
  // Start or end a transaction on this endpoint
  task automatic set_busy(input logic b);
    @(posedge ref_clk_i);
    usb_busy_o <= b;
  endtask : set_busy
endmodule : usb_host_model

/* File: verif/test_endpoint_buffer_context_switch.sv */
`timescale 1ns/100ps
// Self-checking bench for the endpoint context-switch block
module test_endpoint_buffer_context_switch;
  import ep_ctx_pkg::*;
  typedef struct packed {
    logic [7:0]  adr;
    logic        we;
    logic [31:0] dat;
    logic [31:0] exp;
  } row_type;
  logic        ref_clk_i;
  logic        rst_n_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        usb_busy_i;
  logic        tok_valid_i;
  logic        tok_in_i;
  logic [3:0]  tok_ep_i;
  logic        tok_nak_o;
  logic        tok_timeout_o;
  logic        ep_enable_o;
  logic [31:0] q;
  logic        nak;
  logic        tmo;
  int          error_cnt = 0;
  int          n_checks  = 0;
  row_type     rows [0:24];
  ep_ctx_switch dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .usb_busy_i(usb_busy_i),
    .tok_valid_i(tok_valid_i), .tok_in_i(tok_in_i), .tok_ep_i(tok_ep_i),
    .tok_nak_o(tok_nak_o), .tok_timeout_o(tok_timeout_o), .ep_enable_o(ep_enable_o));
  usb_host_model host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tok_nak_i(tok_nak_o),
    .tok_timeout_i(tok_timeout_o), .usb_busy_o(usb_busy_i), .tok_valid_o(tok_valid_i),
    .tok_in_o(tok_in_i), .tok_ep_o(tok_ep_i));
  // Free-running clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // Verdict and end of run
  task automatic wrap_up;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      error_cnt++;
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      $display("BAD %0t no bus answer", $time);
      error_cnt++;
      wrap_up();
    end else begin
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask : wb_xfer
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] d;
    wb_xfer(1'b1, adr, dat, sel, d);
  endtask : wr
  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    wb_xfer(1'b0, adr, 32'h0, 4'hf, d);
    chk(d, exp, msg);
  endtask : rdc
  // Main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    rst_n_i = 1'b0;
    rows[0]  = '{OFS_CFG, 1'b0, 32'h0, 32'h0};
    rows[1]  = '{OFS_TRANSFER, 1'b0, 32'h0, 32'h0};
    rows[2]  = '{OFS_AVAIL, 1'b0, 32'h0, 32'h0};
    rows[3]  = '{OFS_BSTATE, 1'b0, 32'h0, 32'h0};
    rows[4]  = '{OFS_STAT1, 1'b0, 32'h0, 32'h0};
    rows[5]  = '{OFS_RSPSET, 1'b0, 32'h0, 32'h0};
    rows[6]  = '{OFS_IRQENB, 1'b0, 32'h0, 32'h0};
    rows[7]  = '{OFS_MAXPKT, 1'b0, 32'h0, 32'h40};
    rows[8]  = '{OFS_USBCTL1, 1'b0, 32'h0, 32'h0};
    rows[9]  = '{OFS_VIRT_IN, 1'b0, 32'h0, 32'h0};
    rows[10] = '{OFS_VIRT_OUT, 1'b0, 32'h0, 32'h0};
    rows[11] = '{8'h3c, 1'b1, 32'hffffffff, 32'h0};
    rows[12] = '{8'h3c, 1'b0, 32'h0, 32'h0};
    rows[13] = '{OFS_CFG, 1'b1, 32'h73, 32'h0};
    rows[14] = '{OFS_CFG, 1'b0, 32'h0, 32'h73};
    rows[15] = '{OFS_IRQENB, 1'b1, 32'h5a, 32'h0};
    rows[16] = '{OFS_IRQENB, 1'b0, 32'h0, 32'h5a};
    rows[17] = '{OFS_MAXPKT, 1'b1, 32'h200, 32'h0};
    rows[18] = '{OFS_MAXPKT, 1'b0, 32'h0, 32'h200};
    rows[19] = '{OFS_RSPSET, 1'b1, 32'h3, 32'h0};
    rows[20] = '{OFS_RSPCLR, 1'b1, 32'h1, 32'h0};
    rows[21] = '{OFS_RSPSET, 1'b0, 32'h0, 32'h0};
    rows[22] = '{OFS_RSPCLR, 1'b1, 32'hfc, 32'h0};
    rows[23] = '{OFS_RSPSET, 1'b1, 32'h3, 32'h0};
    rows[24] = '{OFS_RSPSET, 1'b0, 32'h0, 32'h3};
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // Table pass: reset values, read back, unmapped place
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].adr, rows[i].dat, 4'hf);
      else rdc(rows[i].adr, rows[i].exp, "register row");
    end
    // IN load, validate by zero count, read back as OUT
    wr(OFS_STAT1, 32'h80, 4'h1);
    for (int i = 0; i < 3; i++) wr(OFS_DATA, 32'ha1 + i, 4'h1);
    rdc(OFS_DATA, 32'h0, "data read while IN");
    rdc(OFS_BSTATE, 32'h4, "unvalidated");
    wr(OFS_TRANSFER, 32'h0, 4'h7);
    rdc(OFS_BSTATE, 32'h1, "waiting for host");
    wr(OFS_CFG, 32'h63, 4'h1);
    rdc(OFS_AVAIL, 32'h3, "avail after switch");
    for (int i = 0; i < 3; i++) rdc(OFS_DATA, 32'ha1 + i, "readback");
    rdc(OFS_AVAIL, 32'h0, "avail drained");
    // Low-byte validation, then an unvalidated tail lost on switch
    wr(OFS_CFG, 32'h73, 4'h1);
    wr(OFS_DATA, 32'h11, 4'h1);
    wr(OFS_TRANSFER, 32'h0, 4'h1);
    wr(OFS_DATA, 32'h22, 4'h1);
    wr(OFS_DATA, 32'h33, 4'h1);
    wr(OFS_CFG, 32'h63, 4'h1);
    rdc(OFS_AVAIL, 32'h1, "low byte validate");
    rdc(OFS_DATA, 32'h11, "low byte data");
    rdc(OFS_BSTATE, 32'h0, "tail discarded");
    // Counter preloaded with the data count validates on last byte
    wr(OFS_CFG, 32'h73, 4'h1);
    wr(OFS_TRANSFER, 32'h2, 4'h7);
    wr(OFS_DATA, 32'h44, 4'h1);
    wr(OFS_DATA, 32'h55, 4'h1);
    rdc(OFS_TRANSFER, 32'h0, "counter run down");
    rdc(OFS_BSTATE, 32'h1, "counted packet valid");
    // Local zero-length packet and its dummy read
    wr(OFS_STAT1, 32'h80, 4'h1);
    wr(OFS_TRANSFER, 32'h0, 4'h7);
    rdc(OFS_STAT1, 32'h40, "zlp flag");
    rdc(OFS_BSTATE, 32'h3, "zlp state IN");
    wr(OFS_CFG, 32'h63, 4'h1);
    rdc(OFS_AVAIL, 32'h0, "zlp no bytes");
    wb_xfer(1'b0, OFS_DATA, 32'h0, 4'hf, q);
    rdc(OFS_STAT1, 32'h0, "zlp removed");
    rdc(OFS_BSTATE, 32'h0, "zlp state gone");
    // Enable held during a transaction, disable polled afterwards
    wr(OFS_CFG, 32'h93, 4'h1);
    #1 chk({31'h0, ep_enable_o}, 32'h1, "enable applied");
    host.set_busy(1'b1);
    wr(OFS_CFG, 32'h13, 4'h1);
    rdc(OFS_CFG, 32'h93, "enable held");
    #1 chk({31'h0, ep_enable_o}, 32'h1, "enable pin held");
    host.set_busy(1'b0);
    q = 32'h80;
    for (int i = 0; i < 8 && q[7] !== 1'b0; i++) wb_xfer(1'b0, OFS_CFG, 32'h0, 4'hf, q);
    chk(q, 32'h13, "disable after transaction");
    wr(OFS_DATA, 32'h66, 4'h1);
    rdc(OFS_BSTATE, 32'h4, "data port while disabled");
    // Unassigned tokens: timeout, then NAK with pending bits
    wr(OFS_CFG, 32'h93, 4'h1);
    host.send_token(1'b1, 4'h5, nak, tmo);
    chk({30'h0, nak, tmo}, 32'h1, "timeout");
    wr(OFS_USBCTL1, 32'h1, 4'h1);
    host.send_token(1'b1, 4'h5, nak, tmo);
    chk({30'h0, nak, tmo}, 32'h2, "nak in");
    host.send_token(1'b0, 4'h3, nak, tmo);
    chk({30'h0, nak, tmo}, 32'h2, "nak wrong dir");
    host.send_token(1'b1, 4'h3, nak, tmo);
    chk({30'h0, nak, tmo}, 32'h0, "assigned");
    rdc(OFS_VIRT_IN, 32'h20, "pending in");
    rdc(OFS_VIRT_OUT, 32'h8, "pending out");
    wr(OFS_VIRT_IN, 32'h20, 4'h3);
    rdc(OFS_VIRT_IN, 32'h0, "pending cleared");
    // Second reset in mid-run
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1 chk({31'h0, ep_enable_o}, 32'h0, "enable after reset");
    rdc(OFS_CFG, 32'h0, "cfg after reset");
    rdc(OFS_MAXPKT, 32'h40, "maxpkt after reset");
    wrap_up();
  end
endmodule : test_endpoint_buffer_context_switch
